//--- rtl/pmid_pkg.sv
// Constants, field layouts and carrier types for the monitor identification registers
package pmid_pkg;

	// ----------------------------------------------------------------
	// Build configuration
	// ----------------------------------------------------------------
	localparam logic               PMID_MON_PRESENT     = 1'b1; // Monitor extension built in
	localparam logic               PMID_TWO_SEC_STATES  = 1'b1; // Two security states built in
	localparam logic               PMID_EXPORT_SUPPORT  = 1'b1; // Event export built in
	localparam int unsigned        PMID_NUM_GROUPS      = 4;
	localparam int unsigned        PMID_GRP_W           = 2;
	localparam logic [3:0]         PMID_CTRS_PER_GROUP  = 4'h4;
	localparam logic [7:0]         PMID_GROUP_TOTAL_M1  = 8'h03; // Groups minus one
	localparam logic [7:0]         PMID_CTR_TOTAL_M1    = 8'h0F; // Counters minus one
	localparam logic [6:0]         PMID_STREAM_GROUP_ID_BASE       = 7'h00; // Stream group of group 0
	// Implemented events: wr/rd/any access, wr/rd/any alloc, cycle/64, cycle
	localparam logic [7:0]         PMID_EVT_IMPL        = 8'hFF;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [11:0]        PMID_OFF_GROUP_CTRL  = 12'h800;
	localparam logic [11:0]        PMID_OFF_CONFIG      = 12'hE00;
	localparam logic [11:0]        PMID_OFF_CONTROL     = 12'hE04;
	localparam logic [11:0]        PMID_OFF_EVT_LO      = 12'hE20;
	localparam logic [11:0]        PMID_OFF_EVT_HI      = 12'hE24;
	localparam logic [11:0]        PMID_OFF_AUTH        = 12'hFB8;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned        PMID_AUTH_TOBS_IMPL  = 7;
	localparam int unsigned        PMID_AUTH_TOBS_ON    = 6;
	localparam int unsigned        PMID_AUTH_OOBS_IMPL  = 3;
	localparam int unsigned        PMID_AUTH_OOBS_ON    = 2;
	localparam int unsigned        PMID_EVT_ACC_LSB     = 16;
	localparam int unsigned        PMID_EVT_ALLOC_LSB   = 8;
	localparam int unsigned        PMID_EVT_CYC_LSB     = 0;
	localparam int unsigned        PMID_CFG_NCG_LSB     = 24;
	localparam int unsigned        PMID_CFG_USER_BIT    = 19;
	localparam int unsigned        PMID_CFG_EX_BIT      = 16;
	localparam int unsigned        PMID_CFG_PRESC_BIT   = 15;
	localparam int unsigned        PMID_CFG_CYC_BIT     = 14;
	localparam int unsigned        PMID_CFG_SIZE_LSB    = 8;
	localparam logic [5:0]         PMID_CFG_SIZE_VAL    = 6'h1F;
	localparam int unsigned        PMID_CFG_N_LSB       = 0;
	localparam int unsigned        PMID_CTL_X_BIT       = 4;
	localparam int unsigned        PMID_CTL_P_BIT       = 1;
	localparam int unsigned        PMID_CTL_E_BIT       = 0;
	localparam int unsigned        PMID_GRP_CNT_LSB     = 24;
	localparam int unsigned        PMID_GRP_STREAM_GROUP_ID_LSB    = 16;
	localparam int unsigned        PMID_GRP_X_BIT       = 12;
	localparam int unsigned        PMID_GRP_E_BIT       = 11;
	localparam int unsigned        PMID_GRP_REVEAL_BIT  = 10;
	localparam int unsigned        PMID_GRP_SCOPE_LSB   = 8;
	localparam int unsigned        PMID_GRP_BANK_LSB    = 0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PMID_SCOPE_GLOBAL = 2'h0,
		PMID_SCOPE_STREAM = 2'h1,
		PMID_SCOPE_BANK   = 2'h2,
		PMID_SCOPE_RSVD   = 2'h3
	} pmid_scope_t;

	typedef struct packed {
		logic        export_on;
		logic        count_on;
		logic        bank_reveal_flag;
		pmid_scope_t count_scope_select;
		logic [7:0]  bank_pointer;
	} pmid_grp_t;

	typedef struct packed {
		logic debug_allow;
		logic observe_allow;
		logic trusted_halt_allow;
		logic trusted_observe_allow;
	} pmid_auth_t;

	localparam pmid_grp_t          PMID_GRP_RESET       = '{1'b0, 1'b0, 1'b0, PMID_SCOPE_GLOBAL, 8'h00};
	localparam logic [31:0]        PMID_WORD_ZERO       = 32'h0000_0000;

endpackage : pmid_pkg

//--- rtl/pmid_group_ctrl.sv
// One counter-group control word with its writable fields and read view
`timescale 1ns/10ps
`default_nettype none
module pmid_group_ctrl
	import pmid_pkg::*;
#(
	parameter logic [PMID_GRP_W-1:0] GRP_INDEX = '0
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        wr_en,
	input  wire logic [31:0] wdata,
	input  wire logic        cb_upd_en,
	input  wire logic        cb_upd_export,
	input  wire logic        cb_upd_enable,
	output var  pmid_grp_t   fields_q,
	output logic [31:0]      rdata
);

	// ----------------------------------------------------------------
	// Field update
	// ----------------------------------------------------------------
	pmid_grp_t   fields_d;
	pmid_scope_t scope_wr;
	logic [6:0]  stream_group_id;

	assign scope_wr = pmid_scope_t'(wdata[PMID_GRP_SCOPE_LSB +: 2]);
	assign stream_group_id     = PMID_STREAM_GROUP_ID_BASE + 7'(GRP_INDEX);

	// Bus write wins over a context-bank mirror update in the same cycle
	always_comb begin
		fields_d = fields_q;
		if (wr_en) begin
			fields_d.export_on        = wdata[PMID_GRP_X_BIT];
			fields_d.count_on         = wdata[PMID_GRP_E_BIT];
			fields_d.bank_reveal_flag = wdata[PMID_GRP_REVEAL_BIT];
			fields_d.bank_pointer     = wdata[PMID_GRP_BANK_LSB +: 8];
			// The reserved scope code is dropped so the scope never holds it
			if (scope_wr != PMID_SCOPE_RSVD) begin
				fields_d.count_scope_select = scope_wr;
			end
		end else if (cb_upd_en) begin
			fields_d.export_on = cb_upd_export;
			fields_d.count_on  = cb_upd_enable;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			fields_q <= PMID_GRP_RESET;
		end else begin
			fields_q <= fields_d;
		end
	end

	// ----------------------------------------------------------------
	// Read view: count and stream group are constants, so writes miss them
	// ----------------------------------------------------------------
	always_comb begin
		rdata = PMID_WORD_ZERO;
		rdata[PMID_GRP_CNT_LSB +: 4]    = PMID_CTRS_PER_GROUP;
		rdata[PMID_GRP_STREAM_GROUP_ID_LSB +: 7]   = stream_group_id;
		rdata[PMID_GRP_X_BIT]           = fields_q.export_on;
		rdata[PMID_GRP_E_BIT]           = fields_q.count_on;
		rdata[PMID_GRP_REVEAL_BIT]      = fields_q.bank_reveal_flag;
		rdata[PMID_GRP_SCOPE_LSB +: 2]  = fields_q.count_scope_select;
		rdata[PMID_GRP_BANK_LSB +: 8]   = fields_q.bank_pointer;
	end

endmodule : pmid_group_ctrl
`default_nettype wire

//--- rtl/pmid_regs.sv
// Identification, configuration and counter-group control registers of the monitor
//
// Operation
// - Two states: open observe-debug enabled bit is debug OR observe input.
// - Two states: trusted observe bit is (debug OR observe) AND (trusted halt OR trusted observe).
// - Two states: both observe-implemented bits read one, all four halt bits zero.
// - One state: trusted observe implemented reads one, enabled is debug OR observe.
// - One state: open observe bits and all halt bits zero; bits 31:8 zero.
// - Event word bits 18:16 flag access write, read and any access events.
// - Event word bits 10:8 flag allocation events for write, read and any.
// - Event word bit 1 cycle/64, bit 0 cycle event; other bits reserved.
// - Upper event word is reserved; an absent extension leaves the map unknown.
// - Config bits 31:24 hold the number of counter groups minus one.
// - Config user-access, prescale and dedicated cycle counter bits read zero.
// - Config export bit shows export support; control export bit writable only then.
// - Config counter size field always reads 0b011111 for 32-bit counters.
// - Config low byte holds counter count minus one, at most 256 counters.
// - Group word shows its counter count, 1 to 15, read only.
// - Group word shows its affiliated stream group, read only.
// - Group export bit mirrors the context bank control export field.
// - Group count-enable bit mirrors the context bank control enable field.
// - Reveal flag exposes the group in the bank chosen by the pointer.
// - Scope: 00 global, 01 stream matches, 10 indexed bank, 11 reserved.
`timescale 1ns/10ps
`default_nettype none
module pmid_regs
	import pmid_pkg::*;
(
	input  wire logic                                 core_clk,
	input  wire logic                                 rst_b,
	input  wire logic                                 reg_req,
	input  wire logic                                 reg_write,
	input  wire logic [11:0]                          reg_addr,
	input  wire logic [31:0]                          reg_wdata,
	output logic                                      reg_ack_q,
	output logic [31:0]                               reg_rdata_q,
	input  wire logic                                 debug_allow_input,
	input  wire logic                                 observe_allow_input,
	input  wire logic                                 trusted_halt_allow_input,
	input  wire logic                                 trusted_observe_allow_input,
	input  wire logic                                 cb_upd_valid,
	input  wire logic [PMID_GRP_W-1:0]                cb_upd_group,
	input  wire logic                                 cb_upd_export,
	input  wire logic                                 cb_upd_enable,
	output var  pmid_grp_t [PMID_NUM_GROUPS-1:0]      grp_fields_q,
	output logic                                      ctl_export_q,
	output logic                                      ctl_enable_q,
	output logic                                      ctr_reset_pulse_q,
	output logic                                      trusted_count_permit_q,
	output logic                                      open_count_permit_q
);

	// ----------------------------------------------------------------
	// Debug permission synchronisers
	// ----------------------------------------------------------------
	// The permission levels come from pins in another domain, so each
	// passes two flip-flops; only the second one is read onward.
	localparam int unsigned AUTH_W = 4;

	logic [AUTH_W-1:0] auth_raw;
	logic [AUTH_W-1:0] auth_meta_q;
	logic [AUTH_W-1:0] auth_sync_q;
	pmid_auth_t        auth;

	assign auth_raw = {debug_allow_input, observe_allow_input,
	                   trusted_halt_allow_input, trusted_observe_allow_input};

	genvar gs;
	generate
		for (gs = 0; gs < AUTH_W; gs++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (!rst_b) begin
					auth_meta_q[gs] <= 1'b0;
					auth_sync_q[gs] <= 1'b0;
				end else begin
					auth_meta_q[gs] <= auth_raw[gs];
					auth_sync_q[gs] <= auth_meta_q[gs];
				end
			end
		end
	endgenerate

	assign auth = pmid_auth_t'(auth_sync_q);

	// ----------------------------------------------------------------
	// Debug authentication status word
	// ----------------------------------------------------------------
	logic any_observe;
	logic trusted_observe;
	logic [31:0] auth_word;

	assign any_observe     = auth.debug_allow | auth.observe_allow;
	assign trusted_observe = any_observe & (auth.trusted_halt_allow | auth.trusted_observe_allow);

	// Halt-debug bits are never set: this unit offers observation only
	always_comb begin
		auth_word = PMID_WORD_ZERO;
		if (PMID_TWO_SEC_STATES) begin
			auth_word[PMID_AUTH_TOBS_IMPL] = 1'b1;
			auth_word[PMID_AUTH_OOBS_IMPL] = 1'b1;
			auth_word[PMID_AUTH_OOBS_ON]   = any_observe;
			auth_word[PMID_AUTH_TOBS_ON]   = trusted_observe;
		end else begin
			auth_word[PMID_AUTH_TOBS_IMPL] = 1'b1;
			auth_word[PMID_AUTH_TOBS_ON]   = any_observe;
		end
	end

	// Counting permissions handed to the counters, from flops
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			trusted_count_permit_q <= 1'b0;
			open_count_permit_q    <= 1'b0;
		end else begin
			trusted_count_permit_q <= auth_word[PMID_AUTH_TOBS_ON];
			open_count_permit_q    <= auth_word[PMID_AUTH_OOBS_ON];
		end
	end

	// ----------------------------------------------------------------
	// Common event identifier words
	// ----------------------------------------------------------------
	logic [31:0] evt_lo_word;
	logic [31:0] evt_hi_word;

	always_comb begin
		evt_lo_word = PMID_WORD_ZERO;
		evt_lo_word[PMID_EVT_ACC_LSB +: 3]   = PMID_EVT_IMPL[7:5];
		evt_lo_word[PMID_EVT_ALLOC_LSB +: 3] = PMID_EVT_IMPL[4:2];
		evt_lo_word[PMID_EVT_CYC_LSB +: 2]   = PMID_EVT_IMPL[1:0];
	end

	// Reserved and unknown; zero is a legal unknown and keeps reads stable
	assign evt_hi_word = PMID_WORD_ZERO;

	// ----------------------------------------------------------------
	// Configuration word
	// ----------------------------------------------------------------
	logic [31:0] cfg_word;

	always_comb begin
		cfg_word = PMID_WORD_ZERO;
		cfg_word[PMID_CFG_NCG_LSB +: 8]  = PMID_GROUP_TOTAL_M1;
		cfg_word[PMID_CFG_USER_BIT]      = 1'b0;
		cfg_word[PMID_CFG_PRESC_BIT]     = 1'b0;
		cfg_word[PMID_CFG_CYC_BIT]       = 1'b0;
		cfg_word[PMID_CFG_EX_BIT]        = PMID_EXPORT_SUPPORT;
		cfg_word[PMID_CFG_SIZE_LSB +: 6] = PMID_CFG_SIZE_VAL;
		cfg_word[PMID_CFG_N_LSB +: 8]    = PMID_CTR_TOTAL_M1;
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Only word-aligned addresses hit; anything else reads zero.
	localparam int unsigned GRP_HI = 2 + PMID_GRP_W;

	logic                  addr_aligned;
	logic                  hit_auth;
	logic                  hit_evt_lo;
	logic                  hit_evt_hi;
	logic                  hit_cfg;
	logic                  hit_ctl;
	logic                  hit_grp;
	logic [PMID_GRP_W-1:0] grp_sel;
	logic                  wr_req;
	logic                  wr_ctl;

	assign addr_aligned = (reg_addr[1:0] == 2'h0);
	assign hit_auth     = addr_aligned & (reg_addr == PMID_OFF_AUTH);
	assign hit_evt_lo   = addr_aligned & (reg_addr == PMID_OFF_EVT_LO);
	assign hit_evt_hi   = addr_aligned & (reg_addr == PMID_OFF_EVT_HI);
	assign hit_cfg      = addr_aligned & (reg_addr == PMID_OFF_CONFIG);
	assign hit_ctl      = addr_aligned & (reg_addr == PMID_OFF_CONTROL);
	assign hit_grp      = addr_aligned & (reg_addr[11:GRP_HI] == PMID_OFF_GROUP_CTRL[11:GRP_HI]);
	assign grp_sel      = reg_addr[GRP_HI-1:2];
	// An absent extension takes no writes at all
	assign wr_req       = reg_req & reg_write & PMID_MON_PRESENT;
	assign wr_ctl       = wr_req & hit_ctl;

	// ----------------------------------------------------------------
	// Monitor control word: export, enable and counter reset
	// ----------------------------------------------------------------
	logic ctl_export_d;
	logic ctl_enable_d;

	// Export only sticks where export exists; otherwise it stays zero
	assign ctl_export_d = wr_ctl ? (reg_wdata[PMID_CTL_X_BIT] & PMID_EXPORT_SUPPORT) : ctl_export_q;
	assign ctl_enable_d = wr_ctl ? reg_wdata[PMID_CTL_E_BIT] : ctl_enable_q;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctl_export_q      <= 1'b0;
			ctl_enable_q      <= 1'b0;
			ctr_reset_pulse_q <= 1'b0;
		end else begin
			ctl_export_q      <= ctl_export_d;
			ctl_enable_q      <= ctl_enable_d;
			ctr_reset_pulse_q <= wr_ctl & reg_wdata[PMID_CTL_P_BIT];
		end
	end

	logic [31:0] ctl_word;

	// The counter reset bit is write-only and reads zero
	always_comb begin
		ctl_word = PMID_WORD_ZERO;
		ctl_word[PMID_CTL_X_BIT] = ctl_export_q;
		ctl_word[PMID_CTL_E_BIT] = ctl_enable_q;
	end

	// ----------------------------------------------------------------
	// Counter-group control words
	// ----------------------------------------------------------------
	// The writer must keep reveal to stream or bank scope and zero an
	// unused pointer; the fields are passed on as written, except a reserved scope code.
	logic [31:0] grp_rd [PMID_NUM_GROUPS];

	genvar gg;
	generate
		for (gg = 0; gg < PMID_NUM_GROUPS; gg++) begin : g_grp
			logic grp_wr;
			logic grp_cb;

			assign grp_wr = wr_req & hit_grp & (grp_sel == PMID_GRP_W'(gg));
			assign grp_cb = cb_upd_valid & (cb_upd_group == PMID_GRP_W'(gg));

			pmid_group_ctrl #(
				.GRP_INDEX     (PMID_GRP_W'(gg))
			) u_grp (
				.core_clk      (core_clk),
				.rst_b         (rst_b),
				.wr_en         (grp_wr),
				.wdata         (reg_wdata),
				.cb_upd_en     (grp_cb),
				.cb_upd_export (cb_upd_export),
				.cb_upd_enable (cb_upd_enable),
				.fields_q      (grp_fields_q[gg]),
				.rdata         (grp_rd[gg])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read selection
	// ----------------------------------------------------------------
	// Read-only words have no write path, so a write there is dropped.
	logic [31:0] rd_word;
	logic [31:0] rd_mapped;

	assign rd_mapped = hit_auth   ? auth_word   :
	                   hit_evt_lo ? evt_lo_word :
	                   hit_evt_hi ? evt_hi_word :
	                   hit_cfg    ? cfg_word    :
	                   hit_ctl    ? ctl_word    :
	                   hit_grp    ? grp_rd[grp_sel] :
	                                PMID_WORD_ZERO;
	assign rd_word   = PMID_MON_PRESENT ? rd_mapped : PMID_WORD_ZERO;

	// ----------------------------------------------------------------
	// Answer
	// ----------------------------------------------------------------
	// Every request is answered one cycle later; writes answer zero data.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reg_ack_q   <= 1'b0;
			reg_rdata_q <= PMID_WORD_ZERO;
		end else begin
			reg_ack_q   <= reg_req;
			reg_rdata_q <= (reg_req & ~reg_write) ? rd_word : PMID_WORD_ZERO;
		end
	end

endmodule : pmid_regs
`default_nettype wire

//--- dv/pmid_regs_properties.sv
// Concurrent checks on the monitor identification register ports
`timescale 1ns/10ps
`default_nettype none
module pmid_regs_chk
	import pmid_pkg::*;
(
	input wire logic                            core_clk,
	input wire logic                            rst_b,
	input wire logic                            reg_req,
	input wire logic                            reg_write,
	input wire logic [11:0]                     reg_addr,
	input wire logic [31:0]                     reg_wdata,
	input wire logic                            reg_ack_q,
	input wire logic [31:0]                     reg_rdata_q,
	input wire logic                            debug_allow_input,
	input wire logic                            observe_allow_input,
	input wire logic                            trusted_halt_allow_input,
	input wire logic                            trusted_observe_allow_input,
	input wire logic                            cb_upd_valid,
	input wire logic [PMID_GRP_W-1:0]           cb_upd_group,
	input wire logic                            cb_upd_export,
	input wire logic                            cb_upd_enable,
	input wire pmid_grp_t [PMID_NUM_GROUPS-1:0] grp_fields_q,
	input wire logic                            ctl_export_q,
	input wire logic                            ctl_enable_q,
	input wire logic                            trusted_count_permit_q,
	input wire logic                            open_count_permit_q
);
	// ----------------------------------------------------------------
	// Decodes and properties
	// ----------------------------------------------------------------
	default clocking cb_main @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Group words at 0x800..0x80C; pins combine before syncing
	wire logic       rd_en    = reg_req & ~reg_write;
	wire logic       grp_hit  = reg_req && (reg_addr[11:4] == 8'h80) && (reg_addr[1:0] == 2'h0);
	wire logic [1:0] gsel     = reg_addr[3:2];
	wire logic       open_in  = debug_allow_input | observe_allow_input;
	wire logic       trust_in = open_in & (trusted_halt_allow_input | trusted_observe_allow_input);

	property p_ack; reg_ack_q == $past(reg_req); endproperty
	a_ack: assert property (p_ack) else $error("answer not one cycle later");
	property p_cfg; rd_en && reg_addr == PMID_OFF_CONFIG |=> reg_rdata_q == 32'h0301_1F0F; endproperty
	a_cfg: assert property (p_cfg) else $error("config word wrong");
	property p_evt; rd_en && reg_addr == PMID_OFF_EVT_LO |=> reg_rdata_q == 32'h0007_0703; endproperty
	a_evt: assert property (p_evt) else $error("event word wrong");
	property p_evt_hi; rd_en && reg_addr == PMID_OFF_EVT_HI |=> reg_rdata_q == 32'h0; endproperty
	a_evt_hi: assert property (p_evt_hi) else $error("upper event word not zero");
	property p_auth; rd_en && reg_addr == PMID_OFF_AUTH |=> (reg_rdata_q & 32'hFFFF_FFBB) == 32'h0000_0088; endproperty
	a_auth: assert property (p_auth) else $error("auth fixed bits wrong");
	property p_grp_ro;
		grp_hit && !reg_write |=> reg_rdata_q[31:13] == {8'h04, 6'h00, $past(gsel), 3'h0};
	endproperty
	a_grp_ro: assert property (p_grp_ro) else $error("group read-only fields wrong");
	property p_grp_wr;
		grp_hit && reg_write |=> grp_fields_q[$past(gsel)].bank_pointer == $past(reg_wdata[7:0])
			&& grp_fields_q[$past(gsel)].bank_reveal_flag == $past(reg_wdata[10])
			&& grp_fields_q[$past(gsel)].count_scope_select == (($past(reg_wdata[9:8]) == 2'h3) ?
				$past(grp_fields_q[gsel].count_scope_select) : $past(reg_wdata[9:8]));
	endproperty
	a_grp_wr: assert property (p_grp_wr) else $error("group write not taken");
	property p_cb;
		cb_upd_valid && !reg_req |=> grp_fields_q[$past(cb_upd_group)].export_on == $past(cb_upd_export)
			&& grp_fields_q[$past(cb_upd_group)].count_on == $past(cb_upd_enable);
	endproperty
	a_cb: assert property (p_cb) else $error("bank update not mirrored");
	property p_ctl;
		reg_req && reg_write && reg_addr == PMID_OFF_CONTROL |=>
			ctl_export_q == $past(reg_wdata[4]) && ctl_enable_q == $past(reg_wdata[0]);
	endproperty
	a_ctl: assert property (p_ctl) else $error("control export not writable");
	// Settled pins only; sync delay left open
	property p_open; (open_in == $past(open_in))[*5] |-> open_count_permit_q == open_in; endproperty
	a_open: assert property (p_open) else $error("open permit wrong");
	property p_trust; (trust_in == $past(trust_in))[*5] |-> trusted_count_permit_q == trust_in; endproperty
	a_trust: assert property (p_trust) else $error("trusted permit wrong");

	c_cfg: cover property (rd_en && reg_addr == PMID_OFF_CONFIG);
	c_cb: cover property (cb_upd_valid && !reg_req);
	c_rsvd: cover property (grp_hit && reg_write && reg_wdata[9:8] == 2'h3);
endmodule : pmid_regs_chk
`default_nettype wire

//--- dv/pmid_regs_bench.sv
// Self-checking bench for the monitor identification registers
`timescale 1ns/10ps
`default_nettype none
module pmid_regs_bench
	import pmid_pkg::*;
;
	logic                              core_clk = 1'h0, rst_b = 1'h0, reg_req = 1'h0, reg_write = 1'h0;
	logic [11:0]                       reg_addr = 12'h000;
	logic [31:0]                       reg_wdata = 32'h0, reg_rdata_q;
	logic                              debug_allow_input = 1'h0, observe_allow_input = 1'h0;
	logic                              trusted_halt_allow_input = 1'h0, trusted_observe_allow_input = 1'h0;
	logic                              cb_upd_valid = 1'h0, cb_upd_export = 1'h0, cb_upd_enable = 1'h0;
	logic [PMID_GRP_W-1:0]             cb_upd_group = 2'h0;
	logic                              reg_ack_q, ctl_export_q, ctl_enable_q, ctr_reset_pulse_q;
	logic                              trusted_count_permit_q, open_count_permit_q;
	pmid_grp_t [PMID_NUM_GROUPS-1:0]   grp_fields_q;
	int                                n_errors = 0, total_checks = 0;

	pmid_regs uut (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack_q(reg_ack_q), .reg_rdata_q(reg_rdata_q),
		.debug_allow_input(debug_allow_input), .observe_allow_input(observe_allow_input),
		.trusted_halt_allow_input(trusted_halt_allow_input),
		.trusted_observe_allow_input(trusted_observe_allow_input), .cb_upd_valid(cb_upd_valid),
		.cb_upd_group(cb_upd_group), .cb_upd_export(cb_upd_export), .cb_upd_enable(cb_upd_enable),
		.grp_fields_q(grp_fields_q), .ctl_export_q(ctl_export_q), .ctl_enable_q(ctl_enable_q),
		.ctr_reset_pulse_q(ctr_reset_pulse_q), .trusted_count_permit_q(trusted_count_permit_q),
		.open_count_permit_q(open_count_permit_q));

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	always #2.5 core_clk = ~core_clk;

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	// One-cycle request; answer taken while the ack stands
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(negedge core_clk);
		{reg_req, reg_write, reg_addr, reg_wdata} = {1'h1, wr, a, d};
		@(negedge core_clk);
		reg_req = 1'h0;
		check_word({31'h0, reg_ack_q}, 32'h1);
		q = reg_rdata_q;
	endtask : bus

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'h0, a, 32'h0, q);
		check_word(q, e);
	endtask : rd_chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
		check_word(q, 32'h0);
	endtask : wr

	// Bank update, optionally racing a zero write to that group
	task automatic cb_pulse(input logic [1:0] g, input logic x, input logic e, input logic race);
		@(negedge core_clk);
		{cb_upd_valid, cb_upd_group, cb_upd_export, cb_upd_enable} = {1'h1, g, x, e};
		{reg_req, reg_write, reg_addr, reg_wdata} = {race, 1'h1, 12'h800 + 12'(4 * g), 32'h0};
		@(negedge core_clk);
		{cb_upd_valid, reg_req} = 2'h0;
	endtask : cb_pulse

	task automatic wrap_up();
		if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_ident();
		rd_chk(PMID_OFF_CONFIG, 32'h0301_1F0F);
		wr(PMID_OFF_CONFIG, 32'h0);
		rd_chk(PMID_OFF_CONFIG, 32'h0301_1F0F);
		rd_chk(PMID_OFF_EVT_LO, 32'h0007_0703);
		rd_chk(PMID_OFF_EVT_HI, 32'h0);
		rd_chk(12'hE08, 32'h0);
		rd_chk(12'hE22, 32'h0);
	endtask : t_ident

	// Every pin combination, held past the synchroniser
	task automatic t_auth();
		logic o, t;
		for (int i = 0; i < 16; i++) begin
			@(negedge core_clk);
			{debug_allow_input, observe_allow_input, trusted_halt_allow_input, trusted_observe_allow_input} = 4'(i);
			o = i[3] | i[2];
			t = o & (i[1] | i[0]);
			repeat (6) @(negedge core_clk);
			rd_chk(PMID_OFF_AUTH, {24'h0, 1'h1, t, 2'h0, 1'h1, o, 2'h0});
			check_word({30'h0, trusted_count_permit_q, open_count_permit_q}, {30'h0, t, o});
		end
	endtask : t_auth

	task automatic t_control();
		wr(PMID_OFF_CONTROL, 32'h13);
		check_word({29'h0, ctr_reset_pulse_q, ctl_export_q, ctl_enable_q}, 32'h7);
		rd_chk(PMID_OFF_CONTROL, 32'h11);
	endtask : t_control

	task automatic t_group();
		logic [31:0] w;
		for (int g = 0; g < 4; g++) begin
			check_word(32'(grp_fields_q[g]), 32'h0);
			rd_chk(12'h800 + 12'(4 * g), {8'h04, 1'h0, 7'(g), 16'h0});
		end
		rd_chk(12'h810, 32'h0);
		wr(12'h804, 32'hFFFF_FDFF);
		rd_chk(12'h804, 32'h0401_1DFF);
		for (int s = 0; s < 3; s++) begin
			w = {21'h0, s != 0, 2'(s), s == 0 ? 8'h00 : 8'h5A};
			wr(12'h808, w);
			rd_chk(12'h808, 32'h0402_0000 | w);
			check_word(32'(grp_fields_q[2]), w);
		end
		wr(12'h808, 32'h0000_0300);
		rd_chk(12'h808, 32'h0402_0200);
	endtask : t_group

	task automatic t_cbank();
		cb_pulse(2'h3, 1'h1, 1'h0, 1'h0);
		rd_chk(12'h80C, 32'h0403_1000);
		cb_pulse(2'h3, 1'h0, 1'h1, 1'h0);
		rd_chk(12'h80C, 32'h0403_0800);
		cb_pulse(2'h3, 1'h1, 1'h1, 1'h1);
		rd_chk(12'h80C, 32'h0403_0000);
	endtask : t_cbank

	// Main sequence after a 20-cycle reset
	initial begin
		repeat (20) @(negedge core_clk);
		rst_b = 1'h1;
		t_ident();
		t_auth();
		t_control();
		t_group();
		t_cbank();
		wrap_up();
	end

	// Run takes under 1000 cycles; stop a hang
	initial begin
		#50000;
		n_errors++;
		wrap_up();
	end
endmodule : pmid_regs_bench

bind pmid_regs pmid_regs_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
	.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack_q(reg_ack_q),
	.reg_rdata_q(reg_rdata_q), .debug_allow_input(debug_allow_input), .observe_allow_input(observe_allow_input),
	.trusted_halt_allow_input(trusted_halt_allow_input), .trusted_observe_allow_input(trusted_observe_allow_input),
	.cb_upd_valid(cb_upd_valid), .cb_upd_group(cb_upd_group), .cb_upd_export(cb_upd_export),
	.cb_upd_enable(cb_upd_enable), .grp_fields_q(grp_fields_q), .ctl_export_q(ctl_export_q),
	.ctl_enable_q(ctl_enable_q), .trusted_count_permit_q(trusted_count_permit_q),
	.open_count_permit_q(open_count_permit_q));
`default_nettype wire
